// [tb/smboe_chk.sv]
`timescale 1ns/1ps
module smboe_chk
	import smboe_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low
	input wire logic scl, // link clock
	input wire logic sda_host_oe, // host pull-low
	input wire logic sda_dev_oe, // device pull-low
	input wire logic sda // resolved data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// wire decoder
	// ------------------------------------------------------------
	logic pscl, psda, frame, addr_ok;
	logic [3:0] bitn;
	logic [2:0] byten, cnt;
	logic [7:0] shreg;
	wire rise = scl && !pscl;
	wire ack_slot = rise && bitn == 4'h8;
	wire start = scl && pscl && psda && !sda;
	wire stop = scl && pscl && !psda && sda;
	// the stop's own scl rise counts as a stray bit, so a clean stop has bitn 1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pscl, psda, frame, addr_ok, bitn, byten, cnt, shreg} <= {2'b11, 20'h0};
		end else begin
			pscl <= scl;
			psda <= sda;
			if (start) begin
				{frame, addr_ok, bitn, byten} <= {2'b10, 7'h0};
			end else if (stop) begin
				frame <= 1'b0;
			end else if (rise && frame && bitn == 4'h8) begin
				bitn <= 4'h0;
				byten <= byten + 3'h1;
				if (byten == 3'h0)
					addr_ok <= shreg == SLAVE_ADDR_WR && !sda;
				if (byten == 3'h2)
					cnt <= shreg[2:0];
			end else if (rise && frame) begin
				shreg <= {shreg[6:0], sda};
				bitn <= bitn + 4'h1;
			end
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_addr_ack; ack_slot && byten == 3'h0 && shreg == SLAVE_ADDR_WR |-> !sda; endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
	property p_ack_all; ack_slot && addr_ok |-> !sda && sda_dev_oe; endproperty
	a_ack_all: assert property (p_ack_all) else $error("byte not acknowledged");
	property p_host_lets_go; ack_slot |-> !sda_host_oe; endproperty
	a_host_lets_go: assert property (p_host_lets_go) else $error("host drove ack slot");
	property p_dev_silent; rise && bitn != 4'h8 |-> !sda_dev_oe; endproperty
	a_dev_silent: assert property (p_dev_silent) else $error("device drove data bit");
	property p_idle_quiet; !frame |-> !sda_dev_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("device drove idle line");
	property p_cmd_zero; ack_slot && byten == 3'h1 |-> shreg == CMD_CODE; endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("command byte not zero");
	property p_count_range;
		ack_slot && byten == 3'h2 |-> shreg != 8'h00 && shreg <= {2'b00, MAX_COUNT};
	endproperty
	a_count_range: assert property (p_count_range) else $error("count out of range");
	property p_stop_on_byte; stop && frame |-> bitn == 4'h1; endproperty
	a_stop_on_byte: assert property (p_stop_on_byte) else $error("stop inside byte");
	property p_frame_len; stop && frame |-> byten == cnt + 3'h3; endproperty
	a_frame_len: assert property (p_frame_len) else $error("data bytes differ from count");
	// main scenarios
	c_one: cover property (stop && frame && byten == 3'h4);
	c_four: cover property (stop && frame && byten == 3'h7);
	c_addr: cover property (ack_slot && byten == 3'h0);
endmodule // smboe_chk

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import smboe_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic src = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, sio_q, intr_q;
	logic [1:0] fix_q;
	logic [7:0] mem_q, pci_q, reg0, reg1, reg2, reg3;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	smboe_if link_if();
	smboe_host smboe_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.link(link_if.host), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	smboe_device smboe_device_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.link(link_if.device), .src_mem_clk({8{src}}), .src_pci_clk({8{src}}),
		.src_sio_clk(src), .src_fixed_clk(src), .src_intr_clk(src), .memory_clock(mem_q),
		.pci_clock(pci_q), .super_io_clock_out(sio_q), .fixed_peripheral_clock_out(fix_q),
		.interrupt_controller_clock_out(intr_q), .peripheral_clock_enables(reg0),
		.memory_clock_enables_low(reg1), .pci_clock_enables(reg2),
		.interrupt_clock_enable(reg3));
	smboe_chk smboe_chk_inst (.pclk(pclk), .presetn(presetn), .scl(link_if.scl),
		.sda_host_oe(link_if.sda_host_oe), .sda_dev_oe(link_if.sda_dev_oe), .sda(link_if.sda));
	// ------------------------------------------------------------
	// clock, timeout, report
	// ------------------------------------------------------------
	initial begin
		forever #5 pclk = ~pclk;
	end
	// a full run needs well under ten thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ------------------------------------------------------------
	// apb access and link transfers
	// ------------------------------------------------------------
	// request stands until pready is high; data and error are taken at that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic send(input logic [31:0] d, input logic [5:0] c);
		apb(1'b1, HOST_DATA0, d);
		apb(1'b1, HOST_CTRL, {18'h0, c, 8'h01});
		apb(1'b0, HOST_STATUS, 32'h0);
		while (rd[STAT_BUSY] !== 1'b0) apb(1'b0, HOST_STATUS, 32'h0);
		chk(rd[2:0], 3'b100);
	endtask
	// the sources are held still so a gated output is either a copy or low
	task automatic chk_all(input logic [7:0] e0, e1, e2, e3);
		src <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		chk({reg3, reg2, reg1, reg0}, {e3, e2, e1, e0});
		chk({8'h0, mem_q, pci_q, 4'h0, sio_q, fix_q, intr_q}, {8'h0, e1, e2, 4'h0,
			e0[SIO_BIT], {2{e0[FIXED_BIT]}}, e3[INTR_BIT]});
		@(posedge pclk);
		src <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		chk({8'h0, mem_q, pci_q, 4'h0, sio_q, fix_q, intr_q}, 32'h0);
		@(posedge pclk);
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_all(8'h06, 8'hff, 8'hff, 8'h08);
		$display("test defaults done");
		send(32'h0034_1204, 6'h04);
		chk_all(8'h04, 8'h12, 8'h34, 8'h00);
		send(32'hffff_ff02, 6'h01);
		chk_all(8'h02, 8'h12, 8'h34, 8'h00);
		send(32'hffff_ff06, 6'h02);
		chk_all(8'h06, 8'hff, 8'h34, 8'h00);
		$display("test block writes done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, HOST_CTRL, {18'h0, ((i == 0) ? 6'h00 : 6'h05), 8'h01});
			apb(1'b0, HOST_STATUS, 32'h0);
			chk(rd[STAT_BUSY], 1'b0);
		end
		apb(1'b0, 8'h0c, 32'h0);
		chk(err, 1'b1);
		chk_all(8'h06, 8'hff, 8'h34, 8'h00);
		$display("test refused orders done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_all(8'h06, 8'hff, 8'hff, 8'h08);
		$display("test second reset done");
		summarize();
	end
endmodule // tb

// [verilog/smboe_device.sv]
`timescale 1ns/1ps
// How it works
// (RULE1) only block writes are accepted
// (RULE2) data bytes land from register 0 upward
// (RULE3) answers write address 11010010 only
// (RULE4) host sends zero command then count
// (RULE5) count is one to thirty-two
// (RULE6) count equals number of data bytes
// (RULE7) command and count bytes are discarded
// (RULE8) transfer valid after count acknowledge
// (RULE9) device acknowledges every received byte
// (RULE10) bits arrive msb first
// (RULE11) host writes zero to reserved bits
// (RULE12) cleared enable holds clock output low
// (RULE13) byte0 bit2 super io, bit1 fixed
// (RULE14) byte1 enables eight memory clocks
// (RULE15) byte2 enables eight pci clocks
// (RULE16) byte3 bit3 enables interrupt clock
// (RULE17) bytes beyond three change no output
// (RULE18) host configures enables at power-on
// (RULE19) register updates only on complete byte
// (RULE20) defaults hold until first valid write
module smboe_device
	import smboe_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low
	input wire logic clk_en, // freezes state when low
	smboe_if.device link, // smbus pins
	input wire logic [7:0] src_mem_clk, // free-running memory clocks
	input wire logic [7:0] src_pci_clk, // free-running pci clocks
	input wire logic src_sio_clk, // super io source
	input wire logic src_fixed_clk, // fixed peripheral source
	input wire logic src_intr_clk, // interrupt controller source
	output logic [7:0] memory_clock, // gated memory clocks
	output logic [7:0] pci_clock, // gated pci clocks
	output logic super_io_clock_out, // gated super io clock
	output logic [1:0] fixed_peripheral_clock_out, // both fixed clocks
	output logic interrupt_controller_clock_out, // gated interrupt clock
	output logic [7:0] peripheral_clock_enables, // register byte 0
	output logic [7:0] memory_clock_enables_low, // register byte 1
	output logic [7:0] pci_clock_enables, // register byte 2
	output logic [7:0] interrupt_clock_enable // register byte 3
);
	typedef enum logic [2:0] {SMBOE_IDLE, SMBOE_ADDR, SMBOE_CMD, SMBOE_CNT,
		SMBOE_DATA, SMBOE_IGNORE} smboe_state_t;

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_d;
		logic sda_d;
		logic [18:0] src_s0; // source clocks, first stage
		logic [18:0] src_s1; // source clocks, second stage
		smboe_state_t state;
		logic [3:0] bitcnt; // 0..7 data bits, 8 = byte in, 9 = ack slot
		logic [7:0] shreg;
		logic [5:0] idx; // data byte index
		logic ack_oe;
		logic [7:0] r0;
		logic [7:0] r1;
		logic [7:0] r2;
		logic [7:0] r3;
		logic [7:0] mem_o;
		logic [7:0] pci_o;
		logic sio_o;
		logic [1:0] fix_o;
		logic intr_o;
	} smboe_dev_t;

	smboe_dev_t st;
	smboe_dev_t next_st;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	// synchronised copies of the source clocks
	logic [7:0] mem_src;
	logic [7:0] pci_src;
	logic sio_src;
	logic fixed_src;
	logic intr_src;

	// ------------------------------------------------------------
	// pin edges, taken from second synchroniser stage only
	// ------------------------------------------------------------
	assign scl_rise = st.scl_sync[1] && !st.scl_d;
	assign scl_fall = !st.scl_sync[1] && st.scl_d;
	assign start_c = st.scl_sync[1] && st.scl_d && st.sda_d && !st.sda_sync[1];
	assign stop_c = st.scl_sync[1] && st.scl_d && !st.sda_d && st.sda_sync[1];

	// ------------------------------------------------------------
	// source clocks, read only after the second stage
	// ------------------------------------------------------------
	assign mem_src = st.src_s1[18:11];
	assign pci_src = st.src_s1[10:3];
	assign sio_src = st.src_s1[2];
	assign fixed_src = st.src_s1[1];
	assign intr_src = st.src_s1[0];

	// ------------------------------------------------------------
	// protocol and register update
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		// two stages on every pin before anything reads it
		next_st.scl_sync = {st.scl_sync[0], link.scl};
		next_st.sda_sync = {st.sda_sync[0], link.sda};
		next_st.scl_d = st.scl_sync[1];
		next_st.sda_d = st.sda_sync[1];
		// the sources are foreign to pclk, so they pass two stages first
		next_st.src_s0 = {src_mem_clk, src_pci_clk, src_sio_clk, src_fixed_clk, src_intr_clk};
		next_st.src_s1 = st.src_s0;
		if (start_c) begin
			// a repeated start simply restarts the address phase
			next_st.state = SMBOE_ADDR;
			next_st.bitcnt = 4'h0;
			next_st.ack_oe = 1'b0;
		end else if (stop_c) begin
			// a byte cut short is simply dropped
			next_st.state = SMBOE_IDLE; // see (RULE19)
			next_st.ack_oe = 1'b0;
		end else if (scl_rise && st.bitcnt < 4'h8 && st.state != SMBOE_IDLE) begin
			next_st.shreg = {st.shreg[6:0], st.sda_sync[1]}; // see (RULE10)
			next_st.bitcnt = st.bitcnt + 4'h1;
		end else if (scl_fall && st.bitcnt == 4'h8) begin
			// eighth bit done: decide and drive ack
			next_st.bitcnt = 4'h9;
			next_st.ack_oe = 1'b1; // see (RULE9)
			case (st.state)
				SMBOE_ADDR: begin
					// read bit set or other address: stay silent
					if (st.shreg == SLAVE_ADDR_WR) begin // see (RULE3) (RULE1)
						next_st.state = SMBOE_CMD;
					end else begin
						next_st.state = SMBOE_IGNORE;
						next_st.ack_oe = 1'b0;
					end
				end
				SMBOE_CMD: next_st.state = SMBOE_CNT; // see (RULE7)
				SMBOE_CNT: begin
					next_st.state = SMBOE_DATA; // see (RULE7) (RULE8)
					next_st.idx = 6'h00; // see (RULE2)
				end
				SMBOE_DATA: begin
					// only whole bytes reach the registers
					case (st.idx) // see (RULE19) (RULE2)
						6'h00: next_st.r0 = st.shreg; // see (RULE13)
						6'h01: next_st.r1 = st.shreg; // see (RULE14)
						6'h02: next_st.r2 = st.shreg; // see (RULE15)
						6'h03: next_st.r3 = st.shreg; // see (RULE16)
						default: ; // see (RULE17)
					endcase
					// saturate so a long block never wraps back onto byte 0
					if (st.idx != 6'h3f) begin
						next_st.idx = st.idx + 6'h01;
					end
				end
				// ignored frames never pull data low
				default: next_st.ack_oe = 1'b0;
			endcase
		end else if (scl_fall && st.bitcnt == 4'h9) begin
			// ack slot over, release line
			next_st.ack_oe = 1'b0;
			next_st.bitcnt = 4'h0;
		end
		// gating: reserved bits never reach a clock output; the register byte outputs carry them
		// a pclk-sampled source is coarse, but gating needs no more
		next_st.mem_o = mem_src & st.r1; // see (RULE12) (RULE14)
		next_st.pci_o = pci_src & st.r2; // see (RULE12) (RULE15)
		next_st.sio_o = sio_src & st.r0[SIO_BIT]; // see (RULE13)
		next_st.fix_o = {2{fixed_src & st.r0[FIXED_BIT]}}; // see (RULE13)
		next_st.intr_o = intr_src & st.r3[INTR_BIT]; // see (RULE16)
	end

	// ------------------------------------------------------------
	// state register; defaults until first write
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			// sync stages start at the pins' idle level, so no false edge
			st.scl_sync <= 2'b11;
			st.sda_sync <= 2'b11;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.state <= SMBOE_IDLE;
			st.r0 <= PERIPH_RESET; // see (RULE20)
			st.r1 <= MEM_RESET;
			st.r2 <= PCI_RESET;
			st.r3 <= INTR_RESET;
		// clock enable low freezes every stage, synchronisers too
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign link.sda_dev_oe = st.ack_oe;
	assign memory_clock = st.mem_o;
	assign pci_clock = st.pci_o;
	assign super_io_clock_out = st.sio_o;
	assign fixed_peripheral_clock_out = st.fix_o;
	assign interrupt_controller_clock_out = st.intr_o;
	assign peripheral_clock_enables = st.r0;
	assign memory_clock_enables_low = st.r1;
	assign pci_clock_enables = st.r2;
	assign interrupt_clock_enable = st.r3;
endmodule // smboe_device

// [verilog/smboe_host.sv]
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module smboe_host
	import smboe_pkg::*;
#(
	parameter int HALF_CYC = SCL_HALF_CYC // pclk cycles per scl half period
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low
	input wire logic clk_en, // freezes state when low
	smboe_if.host link, // smbus pins
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready with no wait state
	output logic pslverr // apb error on unmapped
);
	typedef enum logic [2:0] {SMBOE_H_IDLE, SMBOE_H_START, SMBOE_H_BITS,
		SMBOE_H_ACK, SMBOE_H_STOP} smboe_hstate_t;

	typedef struct packed {
		logic [31:0] data;
		logic [5:0] count;
		logic busy;
		logic nack;
		logic done;
		smboe_hstate_t state;
		logic [7:0] div;
		logic [1:0] phase;
		logic [2:0] bit_i;
		logic [5:0] byte_i; // 0 addr, 1 cmd, 2 count, 3+ data
		logic [1:0] sda_sync;
		logic scl;
		logic sda_oe;
		logic [31:0] rdata;
		logic err;
		logic rdy;
	} smboe_host_t;

	smboe_host_t st;
	smboe_host_t next_st;
	logic tick;
	logic mid;
	logic [7:0] cur_byte;
	logic apb_setup;
	logic apb_acc;

	// byte sent at position i: address, zero command, count, data
	function automatic logic [7:0] smboe_byte(input logic [5:0] i, input logic [31:0] d,
		input logic [5:0] c);
		case (i)
			6'h00: smboe_byte = SLAVE_ADDR_WR; // see (RULE3)
			6'h01: smboe_byte = CMD_CODE; // see (RULE4)
			6'h02: smboe_byte = {2'b00, c}; // see (RULE6)
			6'h03: smboe_byte = d[7:0];
			6'h04: smboe_byte = d[15:8];
			6'h05: smboe_byte = d[23:16];
			default: smboe_byte = d[31:24];
		endcase
	endfunction

	assign tick = (st.div == 8'(HALF_CYC - 1));
	// data moves half way through scl low, clear of both scl edges
	assign mid = (st.div == 8'(HALF_CYC / 2 - 1));
	assign cur_byte = smboe_byte(st.byte_i, st.data, st.count);
	// no wait state: read data and error are registered in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_acc = psel && penable && st.rdy;

	// ------------------------------------------------------------
	// apb slave and bit engine
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sda_sync = {st.sda_sync[0], link.sda};
		next_st.err = 1'b0;
		next_st.rdy = apb_setup;
		if (apb_setup) begin
			case (paddr)
				HOST_DATA0: next_st.rdata = st.data;
				HOST_CTRL: next_st.rdata = {18'h0, st.count, 8'h00};
				HOST_STATUS: next_st.rdata = {29'h0, st.done, st.nack, st.busy};
				default: begin
					next_st.rdata = 32'h0;
					next_st.err = 1'b1;
				end
			endcase
		end
		if (apb_acc && pwrite) begin
			case (paddr)
				HOST_DATA0: if (!st.busy) next_st.data = pwdata;
				HOST_CTRL: begin
					// count limited to the four enable bytes; zero refused
					if (!st.busy && pwdata[CTRL_GO] && pwdata[CTRL_CNT_LSB +: 6] != 6'h0
						&& pwdata[CTRL_CNT_LSB +: 6] <= 6'h04) begin // see (RULE5) (RULE18)
						next_st.count = pwdata[CTRL_CNT_LSB +: 6];
						next_st.busy = 1'b1;
						next_st.done = 1'b0;
						next_st.nack = 1'b0;
						next_st.state = SMBOE_H_START;
						next_st.div = 8'h00;
						next_st.phase = 2'b00;
					end
				end
				HOST_STATUS: ;
				default: ;
			endcase
		end
		if (st.state != SMBOE_H_IDLE) begin
			next_st.div = tick ? 8'h00 : st.div + 8'h01;
		end
		// data and the stop level change only while scl is low
		if (mid && !st.scl) begin
			case (st.state)
				SMBOE_H_BITS: next_st.sda_oe = !cur_byte[st.bit_i]; // see (RULE10)
				SMBOE_H_ACK: next_st.sda_oe = 1'b0;
				SMBOE_H_STOP: next_st.sda_oe = 1'b1;
				default: ;
			endcase
		end
		if (tick) begin
			case (st.state)
				SMBOE_H_START: begin
					// sda falls with scl high, then scl falls
					next_st.sda_oe = 1'b1;
					next_st.phase = st.phase + 2'b01;
					if (st.phase == 2'b01) begin
						next_st.scl = 1'b0;
						next_st.state = SMBOE_H_BITS;
						next_st.bit_i = 3'h7;
						next_st.byte_i = 6'h00;
						next_st.phase = 2'b00;
					end
				end
				SMBOE_H_BITS, SMBOE_H_ACK: begin
					if (!st.scl) begin
						// data was already set up in mid low phase
						next_st.scl = 1'b1;
					end else begin
						next_st.scl = 1'b0;
						if (st.state == SMBOE_H_BITS) begin
							if (st.bit_i == 3'h0) begin
								next_st.state = SMBOE_H_ACK;
							end
							next_st.bit_i = st.bit_i - 3'h1;
						end else begin
							// valid once count ack sampled
							if (st.sda_sync[1]) begin // see (RULE8)
								next_st.nack = 1'b1;
								next_st.state = SMBOE_H_STOP;
							end else if (st.byte_i == st.count + 6'h02) begin // see (RULE6)
								next_st.state = SMBOE_H_STOP;
							end else begin
								next_st.byte_i = st.byte_i + 6'h01; // see (RULE2)
								next_st.state = SMBOE_H_BITS;
								next_st.bit_i = 3'h7;
							end
							next_st.phase = 2'b00;
						end
					end
				end
				SMBOE_H_STOP: begin
					// scl up with sda low, then sda released
					next_st.phase = st.phase + 2'b01;
					if (st.phase == 2'b00) begin
						next_st.scl = 1'b1;
					end else begin
						next_st.sda_oe = 1'b0;
						next_st.state = SMBOE_H_IDLE;
						next_st.busy = 1'b0;
						next_st.done = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.scl <= 1'b1;
			st.sda_sync <= 2'b11;
			st.state <= SMBOE_H_IDLE;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign link.scl = st.scl;
	assign link.sda_host_oe = st.sda_oe;
	assign prdata = st.rdata;
	assign pready = st.rdy;
	assign pslverr = st.err;
endmodule // smboe_host

// [verilog/smboe_if.sv]
`timescale 1ns/1ps
interface smboe_if;
	logic scl; // link clock, host driven
	logic sda_host_oe; // host pulls data low
	logic sda_dev_oe; // device pulls data low
	logic sda; // resolved open-drain level
	assign sda = !(sda_host_oe || sda_dev_oe);
	modport device (input scl, input sda, output sda_dev_oe);
	modport host (output scl, input sda, output sda_host_oe);
endinterface // smboe_if

// [verilog/smboe_pkg.sv]
package smboe_pkg;
	// ------------------------------------------------------------
	// link framing
	// ------------------------------------------------------------
	localparam logic [7:0] SLAVE_ADDR_WR = 8'hd2;
	localparam logic [7:0] CMD_CODE = 8'h00;
	localparam logic [5:0] MAX_COUNT = 6'h20;
	localparam int NUM_REGS = 4;
	// ------------------------------------------------------------
	// register defaults and defined bits
	// ------------------------------------------------------------
	localparam logic [7:0] PERIPH_RESET = 8'h06;
	localparam logic [7:0] MEM_RESET = 8'hff;
	localparam logic [7:0] PCI_RESET = 8'hff;
	localparam logic [7:0] INTR_RESET = 8'h08;
	localparam logic [7:0] PERIPH_MASK = 8'h06;
	localparam logic [7:0] INTR_MASK = 8'h08;
	localparam int SIO_BIT = 2;
	localparam int FIXED_BIT = 1;
	localparam int INTR_BIT = 3;
	// ------------------------------------------------------------
	// host register map (apb byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] HOST_DATA0 = 8'h00;
	localparam logic [7:0] HOST_CTRL = 8'h04;
	localparam logic [7:0] HOST_STATUS = 8'h08;
	localparam int CTRL_GO = 0;
	localparam int CTRL_CNT_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_DONE = 2;
	// ------------------------------------------------------------
	// host link timing
	// ------------------------------------------------------------
	localparam int SCL_HALF_NS = 40;
	localparam int CLK_NS = 10;
	localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
endpackage
